// [core/rsfp_parser.sv]
// Design decisions made here: the register offsets and the Wishbone slave port.
`default_nettype none
`include "rsfp_defs.svh"
module rsfp_parser
   import rsfp_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   output logic             RX_DONE,
   output logic      [7:0]  RX_STATUS
);
   rsfp_state_t   state_ff;
   logic [4:0]    idx_ff;
   logic [7:0]    cnt_ff;
   logic [7:0]    pos_ff;
   logic [7:0]    status_ff;
   logic          done_ff;
   logic          verr_ff;
   logic          cerr_ff;
   logic          ack_ff;
   logic [31:0]   rdat_ff;
   logic [3:0]    cs_ff;
   logic [2:0]    frm_ff;
   logic          ascii_ff;
   logic          two_ff;
   logic [2:0]    sd_ff;
   logic [4:0]    cap_ptr_ff;
   logic [7:0]    cap_ff [`RSFP_NUM_ENT];
   logic          acc;
   logic          wr_en;
   logic          start_req;
   logic [10:0]   ent;
   logic [10:0]   ent_wb;
   rsfp_field_t   ent_type;
   logic [7:0]    ent_val;
   logic [7:0]    eff_cnt;
   logic          fld_end;
   logic          take;
   logic          is_sd;
   logic          sd_bad;
   logic          field_last;
   logic [15:0]   code;
   logic [7:0]    exp_byte;
   logic          feed;
   logic          calc_clear;

   // ==========================================================
   // wishbone slave: ack one cycle after the request, writes land on the acked edge
   assign acc   = WB_CYC_I && WB_STB_I;
   assign wr_en = acc && WB_WE_I && ack_ff;
   assign start_req = wr_en && (WB_ADR_I == `RSFP_OFF_CTRL) && WB_SEL_I[0] && WB_DAT_I[`RSFP_CTRL_START];

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= acc && !ack_ff;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdat_ff <= 32'h00000000;
      end else if (acc && !ack_ff) begin
         if (WB_ADR_I == `RSFP_OFF_CTRL) begin
            rdat_ff <= {19'h00000, sd_ff, two_ff, ascii_ff, frm_ff, cs_ff, 1'b0};
         end else if (WB_ADR_I == `RSFP_OFF_STATUS) begin
            rdat_ff <= {8'h00, pos_ff, 7'h00, done_ff, status_ff};
         end else if ((WB_ADR_I & `RSFP_REGION_MSK) == `RSFP_OFF_FMT) begin
            rdat_ff <= {16'h0000, ent_wb[10:3], 5'h00, ent_wb[2:0]};
         end else if ((WB_ADR_I & `RSFP_REGION_MSK) == `RSFP_OFF_CAP) begin
            rdat_ff <= {24'h000000, cap_ff[WB_ADR_I[5:2]]};
         end else begin
            rdat_ff <= 32'h00000000;
         end
      end
   end

   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = rdat_ff;

   // ==========================================================
   // configuration, a zero start position is forced to one
   always_ff @(posedge CLK) begin
      if (RESET) begin
         cs_ff    <= `RSFP_CS_RST;
         frm_ff   <= `RSFP_FRM_RST;
         ascii_ff <= 1'b0;
         two_ff   <= 1'b0;
         sd_ff    <= 3'h0;
      end else if (wr_en && WB_ADR_I == `RSFP_OFF_CTRL) begin
         if (WB_SEL_I[0]) begin
            cs_ff  <= (WB_DAT_I[`RSFP_CTRL_CS_LSB +: 4] == 4'h0) ? `RSFP_CS_RST : WB_DAT_I[`RSFP_CTRL_CS_LSB +: 4];
            frm_ff <= WB_DAT_I[`RSFP_CTRL_FRM_LSB +: 3];
         end
         if (WB_SEL_I[1]) begin
            ascii_ff <= WB_DAT_I[`RSFP_CTRL_ASCII];
            two_ff   <= WB_DAT_I[`RSFP_CTRL_TWO];
            sd_ff    <= (WB_DAT_I[`RSFP_CTRL_SD_LSB +: 3] > `RSFP_SD_MAX) ? `RSFP_SD_MAX
                                                                          : WB_DAT_I[`RSFP_CTRL_SD_LSB +: 3];
         end
      end
   end

   // ==========================================================
   // format table; rewriting it mid frame is allowed but not sensible
   rsfp_fmt_table u_table (
      .clk     (CLK),
      .reset   (RESET),
      .we      (wr_en && ((WB_ADR_I & `RSFP_REGION_MSK) == `RSFP_OFF_FMT) && WB_SEL_I[0] && WB_SEL_I[1]),
      .waddr   (WB_ADR_I[5:2]),
      .wdata   ({WB_DAT_I[15:8], WB_DAT_I[2:0]}),
      .raddr_a (idx_ff[3:0]),
      .raddr_b (WB_ADR_I[5:2]),
      .rdata_a (ent),
      .rdata_b (ent_wb)
   );

   assign ent_type = rsfp_field_t'(ent[2:0]);
   assign ent_val  = ent[10:3];
   assign eff_cnt  = (ent_val > `RSFP_SKIP_MAX) ? `RSFP_SKIP_MAX : ((ent_val == 8'h00) ? 8'h01 : ent_val);
   assign fld_end  = idx_ff[4] || (ent_type == FLD_END);
   assign take     = (state_ff == ST_RUN) && RX_VALID && !fld_end;
   assign is_sd    = (idx_ff < {2'b00, sd_ff}) && (ent_type == FLD_CONST);
   assign sd_bad   = take && is_sd && (RX_DATA != ent_val);
   assign exp_byte = (two_ff && cnt_ff == 8'h00) ? code[15:8] : code[7:0];

   always_comb begin
      case (ent_type)
         FLD_DATA:   field_last = (cnt_ff == eff_cnt - 8'h01);
         FLD_SKIP:   field_last = (cnt_ff == eff_cnt - 8'h01);
         FLD_CHECK:  field_last = (cnt_ff == {7'h00, two_ff});
         FLD_ENDDLM: field_last = (RX_DATA == ent_val);
         default:    field_last = 1'b1;
      endcase
   end

   // ==========================================================
   // check value, fed from the start position up to the byte before the check field
   assign calc_clear = (start_req && state_ff == ST_IDLE) || sd_bad;
   assign feed = take && !sd_bad && (ent_type != FLD_CHECK) && ({4'h0, cs_ff} <= pos_ff + 8'h01);

   rsfp_check_calc u_calc (
      .clk        (CLK),
      .reset      (RESET),
      .clear      (calc_clear),
      .feed       (feed),
      .din        (RX_DATA),
      .formula    (rsfp_formula_t'(frm_ff)),
      .conv_ascii (ascii_ff),
      .code       (code)
   );

   // ==========================================================
   // frame walk; after completion only a new start request reopens reception
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_ff  <= ST_IDLE;
         idx_ff    <= 5'h00;
         cnt_ff    <= 8'h00;
         pos_ff    <= 8'h00;
         status_ff <= 8'h00;
         done_ff   <= 1'b0;
         verr_ff   <= 1'b0;
         cerr_ff   <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start_req) begin
                  state_ff  <= ST_RUN;
                  idx_ff    <= 5'h00;
                  cnt_ff    <= 8'h00;
                  pos_ff    <= 8'h00;
                  status_ff <= `RSFP_CODE_WAIT;
                  done_ff   <= 1'b0;
                  verr_ff   <= 1'b0;
                  cerr_ff   <= 1'b0;
               end
            end
            ST_RUN: begin
               if (fld_end) begin
                  state_ff <= ST_IDLE;
                  done_ff  <= 1'b1;
                  if (verr_ff) begin
                     status_ff <= `RSFP_CODE_VERIFY;
                  end else if (cerr_ff) begin
                     status_ff <= `RSFP_CODE_CHECK;
                  end else begin
                     status_ff <= `RSFP_CODE_DONE;
                  end
               end else if (sd_bad) begin
                  idx_ff    <= 5'h00;
                  cnt_ff    <= 8'h00;
                  pos_ff    <= 8'h00;
                  status_ff <= `RSFP_CODE_START;
               end else if (take) begin
                  pos_ff <= pos_ff + 8'h01;
                  if (ent_type == FLD_CONST && !is_sd && RX_DATA != ent_val) begin
                     verr_ff <= 1'b1;
                  end
                  if (ent_type == FLD_CHECK && RX_DATA != exp_byte) begin
                     cerr_ff <= 1'b1;
                  end
                  if (field_last) begin
                     idx_ff <= idx_ff + 5'h01;
                     cnt_ff <= 8'h00;
                  end else if (ent_type != FLD_ENDDLM) begin
                     cnt_ff <= cnt_ff + 8'h01;
                  end
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // stored fields only; delimiters, constants, skips and check bytes never land here
   always_ff @(posedge CLK) begin
      if (RESET) begin
         cap_ptr_ff <= 5'h00;
      end else if (start_req && state_ff == ST_IDLE) begin
         cap_ptr_ff <= 5'h00;
      end else if (take && !sd_bad && ent_type == FLD_DATA && !cap_ptr_ff[4]) begin
         cap_ptr_ff <= cap_ptr_ff + 5'h01;
      end
   end

   // cleared on reset so an unused slot reads zero rather than unknown
   always_ff @(posedge CLK) begin
      if (RESET) begin
         cap_ff <= '{default: 8'h00};
      end else if (take && !sd_bad && ent_type == FLD_DATA && !cap_ptr_ff[4]) begin
         cap_ff[cap_ptr_ff[3:0]] <= RX_DATA;
      end
   end

   assign RX_DONE   = done_ff;
   assign RX_STATUS = status_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   a_wait_status: assert property (start_req && state_ff == ST_IDLE |=> status_ff == 8'h20 && !done_ff)
      else $error("wait status not shown after start");
   a_start_retry: assert property (sd_bad |=> status_ff == 8'h07 && state_ff == ST_RUN && idx_ff == 5'h00)
      else $error("start delimiter mismatch not handled");
   a_verify_flag: assert property (take && ent_type == FLD_CONST && !is_sd && RX_DATA != ent_val |=> verr_ff)
      else $error("verification mismatch lost");
   a_verify_code: assert property ($rose(done_ff) && verr_ff |-> status_ff == 8'h4A)
      else $error("verify error status wrong");
   a_clean_code: assert property ($rose(done_ff) && !verr_ff && !cerr_ff |-> status_ff == 8'h40)
      else $error("clean completion status wrong");
   a_check_flag: assert property (take && ent_type == FLD_CHECK && RX_DATA != exp_byte |=> cerr_ff)
      else $error("check mismatch lost");
   a_skip_limit: assert property (take && ent_type == FLD_SKIP |-> cnt_ff < 8'h63)
      else $error("skip run beyond limit");
   a_no_store: assert property (take && ent_type != FLD_DATA |=> $stable(cap_ptr_ff))
      else $error("non data byte stored");
   a_discard_after: assert property (state_ff == ST_IDLE && !start_req |=> $stable(pos_ff) && state_ff == ST_IDLE)
      else $error("byte taken after completion");
   a_start_range: assert property (cs_ff != 4'h0)
      else $error("check start position zero");
   a_check_len: assert property (take && ent_type == FLD_CHECK && !two_ff |=> idx_ff == $past(idx_ff) + 5'h01)
      else $error("one byte check not closed");

   c_clean_done: cover property ($rose(done_ff) && status_ff == 8'h40);
   c_verify_done: cover property ($rose(done_ff) && status_ff == 8'h4A);
   c_check_done: cover property ($rose(done_ff) && status_ff == 8'h48);
   c_start_retry: cover property (sd_bad);
endmodule : rsfp_parser
`default_nettype wire

// [core/rsfp_defs.svh]
// Overview of operation
// - end delimiter not stored, later bytes dropped
// - one check byte after delimiter, then end
// - verification constants compared, result in status
// - verify mismatch completes with status 74
// - stored field byte never flags an error
// - start delimiter mismatch writes 7, keeps waiting
// - after finish, software restarts the receive
// - skip drops bytes, at most 99 in a row
// - check value over start byte to check field
// - check start position from byte 1 to 15
// - five check formulas selectable
// - addition keeps only the low digits
// - negated sum gives two raw bytes
// - optional binary to ASCII hex conversion
// - check code is one or two bytes
// - check mismatch writes an error code
// - status 32 while waiting, 64 when done without error
`ifndef RSFP_DEFS_SVH
`define RSFP_DEFS_SVH
// ==========================================================
// register map, byte addresses
`define RSFP_OFF_CTRL     8'h00
`define RSFP_OFF_STATUS   8'h04
`define RSFP_OFF_FMT      8'h40
`define RSFP_OFF_CAP      8'h80
`define RSFP_REGION_MSK   8'hC0
// ==========================================================
// control fields
`define RSFP_CTRL_START   0
`define RSFP_CTRL_CS_LSB  1
`define RSFP_CTRL_FRM_LSB 5
`define RSFP_CTRL_ASCII   8
`define RSFP_CTRL_TWO     9
`define RSFP_CTRL_SD_LSB  10
`define RSFP_CS_RST       4'h1
`define RSFP_FRM_RST      3'h0
`define RSFP_SD_MAX       3'h5
// ==========================================================
// status fields and codes
`define RSFP_STAT_DONE    8
`define RSFP_STAT_CNT_LSB 16
`define RSFP_CODE_WAIT    8'h20
`define RSFP_CODE_DONE    8'h40
`define RSFP_CODE_START   8'h07
`define RSFP_CODE_VERIFY  8'h4A
`define RSFP_CODE_CHECK   8'h48
`define RSFP_SKIP_MAX     8'h63
`define RSFP_NUM_ENT      16
`endif

// [core/rsfp_pkg.sv]
`default_nettype none
package rsfp_pkg;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } rsfp_state_t;
   typedef enum logic [2:0] {
      FLD_END    = 3'b000,
      FLD_CONST  = 3'b001,
      FLD_DATA   = 3'b010,
      FLD_SKIP   = 3'b011,
      FLD_ENDDLM = 3'b100,
      FLD_CHECK  = 3'b101
   } rsfp_field_t;
   typedef enum logic [2:0] {
      FRM_XOR = 3'b000,
      FRM_ADD = 3'b001,
      FRM_NEG = 3'b010,
      FRM_LRC = 3'b011,
      FRM_CRC = 3'b100
   } rsfp_formula_t;
endpackage : rsfp_pkg
`default_nettype wire

// [core/rsfp_fmt_table.sv]
`default_nettype none
`include "rsfp_defs.svh"
module rsfp_fmt_table
   import rsfp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        we,
   input  wire logic [3:0]  waddr,
   input  wire logic [10:0] wdata,
   input  wire logic [3:0]  raddr_a,
   input  wire logic [3:0]  raddr_b,
   output logic      [10:0] rdata_a,
   output logic      [10:0] rdata_b
);
   // ==========================================================
   // entry storage: value in [10:3], field kind in [2:0]
   logic [10:0] ent_ff [`RSFP_NUM_ENT];

   genvar gi;
   generate
      for (gi = 0; gi < `RSFP_NUM_ENT; gi++) begin : g_ent
         always_ff @(posedge clk) begin
            if (reset) begin
               ent_ff[gi] <= 11'h000;
            end else if (we && (waddr == 4'(gi))) begin
               ent_ff[gi] <= wdata;
            end
         end
      end
   endgenerate

   assign rdata_a = ent_ff[raddr_a];
   assign rdata_b = ent_ff[raddr_b];
endmodule : rsfp_fmt_table
`default_nettype wire

// [core/rsfp_check_calc.sv]
`default_nettype none
module rsfp_check_calc
   import rsfp_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic          clear,
   input  wire logic          feed,
   input  wire logic [7:0]    din,
   input  wire rsfp_formula_t formula,
   input  wire logic          conv_ascii,
   output logic      [15:0]   code
);
   logic [7:0]  x_ff;
   logic [15:0] s_ff;
   logic [15:0] c_ff;
   logic [7:0]  v8;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int k = 0; k < 8; k++) begin
         r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
      end
      return r;
   endfunction : crc_step

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction : hex_char

   // ==========================================================
   // accumulators, all formulas run in parallel
   always_ff @(posedge clk) begin
      if (reset || clear) begin
         x_ff <= 8'h00;
         s_ff <= 16'h0000;
         c_ff <= 16'hFFFF;
      end else if (feed) begin
         x_ff <= x_ff ^ din;
         s_ff <= s_ff + {8'h00, din};
         c_ff <= crc_step(c_ff, din);
      end
   end

   // ==========================================================
   // code as it must appear on the line; low byte is the last one received
   always_comb begin
      case (formula)
         FRM_ADD: v8 = s_ff[7:0];
         FRM_LRC: v8 = 8'h00 - s_ff[7:0];
         FRM_CRC: v8 = c_ff[7:0];
         default: v8 = x_ff;
      endcase
      if (formula == FRM_NEG) begin
         code = 16'h0000 - s_ff;
      end else if (formula == FRM_CRC && !conv_ascii) begin
         code = {c_ff[7:0], c_ff[15:8]};
      end else if (conv_ascii) begin
         code = {hex_char(v8[7:4]), hex_char(v8[3:0])};
      end else begin
         code = {8'h00, v8};
      end
   end
endmodule : rsfp_check_calc
`default_nettype wire

// [verification/rsfp_station.sv]
`default_nettype none
// ==========================================
// remote station model: one-cycle valid pulse per byte
module rsfp_station (
   input  wire logic       clk,
   output logic      [7:0] data,
   output logic            valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q [$];
   initial begin
      data  = 8'h00;
      valid = 1'b0;
   end
   // gap 0 sends back to back; between bytes the line shows the
   // inverse of the last byte so a stale value never passes as data
   task automatic burst(input int gap);
      logic [7:0] b;
      b = 8'h00;
      while (q.size() > 0) begin
         b = q.pop_front();
         data  <= b;
         valid <= 1'b1;
         @(posedge clk);
         if (gap > 0) begin
            valid <= 1'b0;
            data  <= ~b;
            repeat (gap) @(posedge clk);
         end
      end
      if (gap == 0) begin
         valid <= 1'b0;
         data  <= ~b;
      end
   endtask : burst
endmodule : rsfp_station
`default_nettype wire

// [verification/rsfp_parser_tb.sv]
`default_nettype none
module rsfp_parser_tb
   import rsfp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [3:0] cs;
      logic [2:0] f;
      logic       a, t;
      logic [7:0] n, c1, c2, st;
   } rsfp_case_t;
   localparam logic [31:0] M9 = 32'h1FF, MALL = 32'hFFFFFFFF;
   logic        clk, reset, cyc, stb, we, ack, rx_valid, rx_done;
   logic [7:0]  adr, rx_data, rx_status;
   logic [3:0]  sel, lanes;
   logic [31:0] dat_w, dat_r, rd;
   int          miscompares, n_checks, cycles;
   // bytes are 41h upward; c2 only sent for two-byte checks
   rsfp_case_t  tab [12] = '{
      '{4'h1, FRM_XOR, 1'b0, 1'b0, 8'h04, 8'h04, 8'h00, 8'h40},
      '{4'h1, FRM_XOR, 1'b1, 1'b1, 8'h04, 8'h30, 8'h34, 8'h40},
      '{4'h1, FRM_ADD, 1'b0, 1'b0, 8'h04, 8'h0A, 8'h00, 8'h40},
      '{4'h1, FRM_ADD, 1'b0, 1'b1, 8'h04, 8'h00, 8'h0A, 8'h40},
      '{4'h1, FRM_ADD, 1'b1, 1'b1, 8'h04, 8'h30, 8'h41, 8'h40},
      '{4'h1, FRM_NEG, 1'b0, 1'b1, 8'h04, 8'hFE, 8'hF6, 8'h40},
      '{4'h1, FRM_LRC, 1'b1, 1'b1, 8'h04, 8'h46, 8'h36, 8'h40},
      '{4'h1, FRM_CRC, 1'b0, 1'b1, 8'h04, 8'h85, 8'h0F, 8'h40},
      '{4'h1, FRM_CRC, 1'b1, 1'b1, 8'h04, 8'h38, 8'h35, 8'h40},
      '{4'h2, FRM_XOR, 1'b0, 1'b0, 8'h04, 8'h45, 8'h00, 8'h40},
      '{4'hF, FRM_XOR, 1'b0, 1'b0, 8'h10, 8'h1F, 8'h00, 8'h40},
      '{4'h1, FRM_XOR, 1'b0, 1'b0, 8'h04, 8'h05, 8'h00, 8'h48}};
   // ==========================================
   // design and far side
   rsfp_parser i_dut (
      .CLK       (clk),
      .RESET     (reset),
      .WB_CYC_I  (cyc),
      .WB_STB_I  (stb),
      .WB_WE_I   (we),
      .WB_ADR_I  (adr),
      .WB_SEL_I  (sel),
      .WB_DAT_I  (dat_w),
      .WB_DAT_O  (dat_r),
      .WB_ACK_O  (ack),
      .RX_DATA   (rx_data),
      .RX_VALID  (rx_valid),
      .RX_DONE   (rx_done),
      .RX_STATUS (rx_status)
   );
   rsfp_station i_station (
      .clk   (clk),
      .data  (rx_data),
      .valid (rx_valid)
   );
   // ==========================================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         final_report();
      end
   end
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // classic single cycle; no latency assumed, the hang guard ends a lost ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      sel   <= lanes;
      adr   <= a;
      dat_w <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask : rdchk
   task automatic fmt(input int i, input logic [2:0] k, input logic [7:0] v);
      wb(1'b1, 8'h40 + 8'(4 * i), {16'h0, v, 5'h00, k});
   endtask : fmt
   task automatic go(input logic [3:0] cs, input logic [2:0] f, input logic a, t, input logic [2:0] sd);
      wb(1'b1, 8'h00, {19'h0, sd, t, a, f, cs, 1'b1});
   endtask : go
   task automatic wait_done;
      while (rx_done !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask : wait_done
   task automatic final_report;
      if (miscompares == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   // ==========================================
   // main sequence
   initial begin
      reset = 1'b1;
      {cyc, stb, we, adr, dat_w, rd, sel} = '0;
      lanes = 4'hF;
      miscompares = 0;
      n_checks = 0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rdchk(8'h00, MALL, 32'h2);
      rdchk(8'h3C, MALL, 32'h0);
      rdchk(8'h04, MALL, 32'h0);
      // start delimiter, stored byte, end delimiter
      fmt(0, FLD_CONST, 8'h05);
      fmt(1, FLD_DATA, 8'h00);
      fmt(2, FLD_ENDDLM, 8'h03);
      go(4'h1, FRM_XOR, 1'b0, 1'b0, 3'h1);
      rdchk(8'h04, M9, 32'h20);
      i_station.q = '{8'h06};
      i_station.burst(2);
      rdchk(8'h04, M9, 32'h07);
      i_station.q = '{8'h05, 8'hAA, 8'h03, 8'h77};
      i_station.burst(1);
      wait_done();
      rdchk(8'h04, M9, 32'h140);
      rdchk(8'h80, MALL, 32'hAA);
      rdchk(8'h84, MALL, 32'h0);
      i_station.q = '{8'h05, 8'hBB, 8'h03};
      i_station.burst(0);
      rdchk(8'h80, MALL, 32'hAA);
      // verification constants: mismatch first, then a clean frame
      fmt(2, FLD_CONST, 8'hFF);
      fmt(3, FLD_DATA, 8'h00);
      fmt(4, FLD_CONST, 8'h0D);
      for (int k = 0; k < 2; k++) begin
         go(4'h1, FRM_XOR, 1'b0, 1'b0, 3'h1);
         i_station.q = '{8'h05, 8'h11, k ? 8'hFF : 8'h0F, 8'h22, 8'h0D};
         i_station.burst(0);
         wait_done();
         chk({24'h0, rx_status}, k ? 32'h40 : 32'h4A);
         chk({31'h0, rx_done}, 32'h1);
      end
      // skip count above the limit is held to 99
      fmt(0, FLD_DATA, 8'h00);
      fmt(1, FLD_SKIP, 8'hC8);
      fmt(2, FLD_DATA, 8'h00);
      fmt(3, FLD_END, 8'h00);
      go(4'h1, FRM_XOR, 1'b0, 1'b0, 3'h0);
      i_station.q = '{8'hA1};
      repeat (99) i_station.q.push_back(8'h5A);
      i_station.q.push_back(8'hB2);
      i_station.burst(0);
      wait_done();
      rdchk(8'h80, MALL, 32'hA1);
      rdchk(8'h84, MALL, 32'hB2);
      rdchk(8'h04, M9, 32'h140);
      // check formulas, start positions, lengths and conversions
      fmt(1, FLD_CHECK, 8'h00);
      fmt(2, FLD_END, 8'h00);
      foreach (tab[j]) begin
         fmt(0, FLD_SKIP, tab[j].n);
         go(tab[j].cs, tab[j].f, tab[j].a, tab[j].t, 3'h0);
         for (int b = 1; b <= tab[j].n; b++) i_station.q.push_back(8'h40 + 8'(b));
         i_station.q.push_back(tab[j].c1);
         if (tab[j].t) i_station.q.push_back(tab[j].c2);
         i_station.burst(j % 3);
         wait_done();
         chk({24'h0, rx_status}, {24'h0, tab[j].st});
      end
      // one check byte after the end delimiter, later byte dropped
      fmt(0, FLD_SKIP, 8'h04);
      fmt(1, FLD_ENDDLM, 8'h03);
      fmt(2, FLD_CHECK, 8'h00);
      go(4'h1, FRM_XOR, 1'b0, 1'b0, 3'h0);
      i_station.q = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h03, 8'h07, 8'h99};
      i_station.burst(0);
      wait_done();
      rdchk(8'h04, 32'h00FF01FF, 32'h00060140);
      // byte lanes: a format entry needs lanes 0 and 1, start needs lane 0
      lanes = 4'h1;
      fmt(5, FLD_CONST, 8'h77);
      lanes = 4'h2;
      go(4'h5, FRM_CRC, 1'b1, 1'b1, 3'h2);
      lanes = 4'hF;
      rdchk(8'h54, MALL, 32'h0);
      rdchk(8'h00, MALL, 32'hB02);
      rdchk(8'h04, M9, 32'h140);
      final_report();
   end
endmodule : rsfp_parser_tb
`default_nettype wire
